// file: include/bpc_consts.svh
// register offsets, field positions, bus address and timing figures of the protector register bank
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH

`define BPC_BUS_ADDR 7'h10

`define BPC_REG_STATUS 8'h00
`define BPC_REG_OUT_CTRL 8'h01
`define BPC_REG_STATE_CTRL 8'h02
`define BPC_REG_FUNC_CTRL 8'h03
`define BPC_REG_BALANCE 8'h04
`define BPC_REG_CELL_SEL 8'h05
`define BPC_REG_HIGH_CFG 8'h06
`define BPC_REG_LOW_CFG 8'h07
`define BPC_REG_LVL_DELAY 8'h08
`define BPC_REG_OVL_DELAY 8'h09
`define BPC_REG_SHORT_CFG 8'h0a
`define BPC_REG_NVM_EN 8'h0b
`define BPC_MISC_FIRST 8'h03
`define BPC_MISC_COUNT 9

`define BPC_ST_SHORT 0
`define BPC_ST_OVERLOAD 1
`define BPC_ST_HIGH 2
`define BPC_ST_LOW 3
`define BPC_ST_TEMP 4
`define BPC_ST_SUPPLY 5
`define BPC_ST_DSG 6
`define BPC_ST_CHG 7

`define BPC_OC_RELEASE 0
`define BPC_OC_DSG 1
`define BPC_OC_CHG 2
`define BPC_OC_ODRAIN 3
`define BPC_OC_PARITY 6
`define BPC_OC_RATE 7

`define BPC_SC_SHUTDOWN_REQUEST 0
`define BPC_SC_HOST 1
`define BPC_SC_VSCALE 6
`define BPC_SC_CURRENT_AMP_GAIN 7

`define BPC_RESET_BYTE 8'h00

`define BPC_CLK_MHZ 250
`define BPC_UV_SLOW_MS 50
`define BPC_UV_FAST_US 100

`endif

// file: include/bpc_pkg.sv
// types of the protector register bank
package bpc_pkg;
	typedef enum logic [2:0] {
		BPC_IDLE = 3'b000,
		BPC_ADDR = 3'b001,
		BPC_ACK = 3'b010,
		BPC_WRITE = 3'b011,
		BPC_READ = 3'b100,
		BPC_RACK = 3'b101
	} bpc_bus_state_type;
endpackage : bpc_pkg

// file: design/bpc_regs.sv
// protector register bank with serial slave, fault latches and fet control
// Notes on behaviour
// - status bit0 flags short-circuit current at threshold
// - status bit1 flags current above overload threshold
// - status bit2 flags cell above overvoltage threshold
// - status bit3 flags cell below undervoltage threshold
// - status bit4 flags temperature above its threshold
// - status bit5 shows nvm programming supply good
// - status bits6,7 show discharge and charge fet
// - release toggle 0-1-0 clears latches at status read
// - host mode: control bit1 drives discharge fet while the shutdown bit is clear
// - host mode: control bit2 drives charge fet
// - control bit3 pulls open-drain output low unless a stand-alone parity fault is latched
// - control bit6 is read-only nvm parity fault
// - control bit7 picks slow or fast low sampling
// - host mode shutdown bit enters shutdown at 0 V
// - state bit1 selects stand-alone or host mode
// - state bit6 selects cell amplifier scale
// - state bit7 selects current amplifier gain
// - slave only, seven-bit address 0010000
// - no address auto-increment; pointer is reused
// - host-mode parity fault only flags and alerts
`timescale 1ns/1ns
`include "bpc_consts.svh"

module bpc_regs
	import bpc_pkg::*;
#(
	parameter int unsigned UV_SLOW_CYCLES = `BPC_UV_SLOW_MS * 1000 * `BPC_CLK_MHZ,
	parameter int unsigned UV_FAST_CYCLES = `BPC_UV_FAST_US * `BPC_CLK_MHZ
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic short_circuit_detect,
	input wire logic overload_detect,
	input wire logic cell_high_detect,
	input wire logic cell_low_detect,
	input wire logic over_temp_detect,
	input wire logic nvm_supply_detect,
	input wire logic parity_error_detect,
	input wire logic pack_zero_detect,
	input wire logic discharge_fet_sense,
	input wire logic charge_fet_sense,
	output logic discharge_fet,
	output logic charge_fet,
	output logic open_drain_output_out,
	output logic open_drain_output_oe_n,
	output logic alert_output_n,
	output logic uv_sample_strobe,
	output logic shutdown_enter,
	output logic host_mode,
	output logic cell_amp_scale,
	output logic current_amp_gain,
	output logic [7:0] function_ctrl,
	output logic [7:0] cell_balance,
	output logic [7:0] cell_select
);

	logic [11:0] sync1_r;
	logic [11:0] sync2_r;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_s;
	logic sda_s;
	logic [4:0] fault_live;
	logic nvm_ok;
	logic parity_in;
	logic pack_zero;
	logic dsg_sense;
	logic chg_sense;

	bpc_bus_state_type state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic ptr_pending_r;
	logic rw_r;
	logic nack_r;
	logic drive_low_r;
	logic wr_pulse_r;
	logic [7:0] wr_ptr_r;
	logic [7:0] wr_data_r;
	logic status_read_r;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;
	logic [7:0] rdata;

	logic rate_sel_r;
	logic odrain_r;
	logic chg_ctl_r;
	logic dsg_ctl_r;
	logic release_r;
	logic current_amp_gain_r;
	logic vscale_r;
	logic host_r;
	logic shutdown_request_r;
	logic [7:0] misc_r [`BPC_MISC_COUNT];
	logic [7:0] misc_idx;
	logic misc_hit;
	logic [7:0] wr_idx;
	logic wr_misc_hit;

	logic [4:0] fault_r;
	logic release_armed_r;
	logic parity_r;
	logic [23:0] sample_cnt_r;
	logic [23:0] sample_limit;
	logic dsg_allow;
	logic chg_allow;

	// two-stage synchronisers for every pin input
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_r <= 12'h000;
			sync2_r <= 12'h000;
		end else begin
			sync1_r <= {scl_in, sda_in, short_circuit_detect, overload_detect, cell_high_detect,
				cell_low_detect, over_temp_detect, nvm_supply_detect, parity_error_detect,
				pack_zero_detect, discharge_fet_sense, charge_fet_sense};
			sync2_r <= sync1_r;
		end
	end

	assign scl_s = sync2_r[11];
	assign sda_s = sync2_r[10];
	assign fault_live = {sync2_r[5], sync2_r[6], sync2_r[7], sync2_r[8], sync2_r[9]};
	assign nvm_ok = sync2_r[4];
	assign parity_in = sync2_r[3];
	assign pack_zero = sync2_r[2];
	assign dsg_sense = sync2_r[1];
	assign chg_sense = sync2_r[0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	assign start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;

	// read mux; reserved bits read as zero
	assign misc_idx = ptr_r - `BPC_MISC_FIRST;
	assign misc_hit = (ptr_r >= `BPC_REG_FUNC_CTRL) && (ptr_r <= `BPC_REG_NVM_EN);
	always_comb begin
		rdata = 8'h00;
		if (ptr_r == `BPC_REG_STATUS) begin
			rdata[`BPC_ST_TEMP:`BPC_ST_SHORT] = fault_r;
			rdata[`BPC_ST_SUPPLY] = nvm_ok;
			rdata[`BPC_ST_DSG] = dsg_sense;
			rdata[`BPC_ST_CHG] = chg_sense;
		end else if (ptr_r == `BPC_REG_OUT_CTRL) begin
			rdata[`BPC_OC_RELEASE] = release_r;
			rdata[`BPC_OC_DSG] = dsg_ctl_r;
			rdata[`BPC_OC_CHG] = chg_ctl_r;
			rdata[`BPC_OC_ODRAIN] = odrain_r;
			rdata[`BPC_OC_PARITY] = parity_r;
			rdata[`BPC_OC_RATE] = rate_sel_r;
		end else if (ptr_r == `BPC_REG_STATE_CTRL) begin
			rdata[`BPC_SC_SHUTDOWN_REQUEST] = shutdown_request_r;
			rdata[`BPC_SC_HOST] = host_r;
			rdata[`BPC_SC_VSCALE] = vscale_r;
			rdata[`BPC_SC_CURRENT_AMP_GAIN] = current_amp_gain_r;
		end else if (misc_hit) begin
			rdata = misc_r[misc_idx[3:0]];
		end
	end

	// serial slave: address, then pointer, then data bytes at the same pointer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= BPC_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			ptr_pending_r <= 1'b0;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			drive_low_r <= 1'b0;
			wr_pulse_r <= 1'b0;
			wr_ptr_r <= 8'h00;
			wr_data_r <= 8'h00;
			status_read_r <= 1'b0;
		end else begin
			wr_pulse_r <= 1'b0;
			status_read_r <= 1'b0;
			if (stop_cond) begin
				state_r <= BPC_IDLE;
				drive_low_r <= 1'b0;
			end else if (start_cond) begin
				state_r <= BPC_ADDR;
				bit_cnt_r <= 4'h0;
				drive_low_r <= 1'b0;
			end else begin
				unique case (state_r)
					BPC_IDLE: begin
					end
					BPC_ADDR, BPC_WRITE: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall && bit_cnt_r == 4'h8) begin
							bit_cnt_r <= 4'h0;
							if (state_r == BPC_ADDR) begin
								if (shift_r[7:1] == `BPC_BUS_ADDR) begin
									rw_r <= shift_r[0];
									ptr_pending_r <= !shift_r[0];
									state_r <= BPC_ACK;
									drive_low_r <= 1'b1;
								end else begin
									state_r <= BPC_IDLE;
								end
							end else begin
								if (ptr_pending_r) begin
									ptr_r <= shift_r;
									ptr_pending_r <= 1'b0;
								end else begin
									wr_pulse_r <= 1'b1;
									wr_ptr_r <= ptr_r;
									wr_data_r <= shift_r;
								end
								state_r <= BPC_ACK;
								drive_low_r <= 1'b1;
							end
						end
					end
					BPC_ACK: begin
						if (scl_fall) begin
							bit_cnt_r <= 4'h0;
							if (rw_r) begin
								state_r <= BPC_READ;
								drive_low_r <= !rdata[7];
								shift_r <= {rdata[6:0], 1'b1};
								status_read_r <= (ptr_r == `BPC_REG_STATUS);
							end else begin
								state_r <= BPC_WRITE;
								drive_low_r <= 1'b0;
							end
						end
					end
					BPC_READ: begin
						if (scl_rise) begin
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt_r == 4'h8) begin
								state_r <= BPC_RACK;
								drive_low_r <= 1'b0;
							end else begin
								drive_low_r <= !shift_r[7];
								shift_r <= {shift_r[6:0], 1'b1};
							end
						end
					end
					BPC_RACK: begin
						if (scl_rise) begin
							nack_r <= sda_s;
						end else if (scl_fall) begin
							if (nack_r) begin
								state_r <= BPC_IDLE;
							end else begin
								state_r <= BPC_READ;
								bit_cnt_r <= 4'h0;
								drive_low_r <= !rdata[7];
								shift_r <= {rdata[6:0], 1'b1};
								status_read_r <= (ptr_r == `BPC_REG_STATUS);
							end
						end
					end
					default: begin
						state_r <= BPC_IDLE;
						drive_low_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// register writes; status and read-only bits take no write
	assign wr_idx = wr_ptr_r - `BPC_MISC_FIRST;
	assign wr_misc_hit = (wr_ptr_r >= `BPC_REG_FUNC_CTRL) && (wr_ptr_r <= `BPC_REG_NVM_EN);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rate_sel_r <= 1'b0;
			odrain_r <= 1'b0;
			chg_ctl_r <= 1'b0;
			dsg_ctl_r <= 1'b0;
			release_r <= 1'b0;
			current_amp_gain_r <= 1'b0;
			vscale_r <= 1'b0;
			host_r <= 1'b0;
			shutdown_request_r <= 1'b0;
			for (int i = 0; i < `BPC_MISC_COUNT; i++) begin
				misc_r[i] <= `BPC_RESET_BYTE;
			end
		end else if (wr_pulse_r) begin
			if (wr_ptr_r == `BPC_REG_OUT_CTRL) begin
				release_r <= wr_data_r[`BPC_OC_RELEASE];
				dsg_ctl_r <= wr_data_r[`BPC_OC_DSG];
				chg_ctl_r <= wr_data_r[`BPC_OC_CHG];
				odrain_r <= wr_data_r[`BPC_OC_ODRAIN];
				rate_sel_r <= wr_data_r[`BPC_OC_RATE];
			end else if (wr_ptr_r == `BPC_REG_STATE_CTRL) begin
				shutdown_request_r <= wr_data_r[`BPC_SC_SHUTDOWN_REQUEST];
				host_r <= wr_data_r[`BPC_SC_HOST];
				vscale_r <= wr_data_r[`BPC_SC_VSCALE];
				current_amp_gain_r <= wr_data_r[`BPC_SC_CURRENT_AMP_GAIN];
			end else if (wr_misc_hit) begin
				misc_r[wr_idx[3:0]] <= wr_data_r;
			end
		end
	end

	// fault latches: a live fault sets; an armed release lets the next status read reload them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_r <= 5'h00;
			release_armed_r <= 1'b0;
		end else begin
			if (release_armed_r && status_read_r) begin
				fault_r <= fault_live;
				release_armed_r <= 1'b0;
			end else begin
				fault_r <= fault_r | fault_live;
			end
			if (wr_pulse_r && wr_ptr_r == `BPC_REG_OUT_CTRL && release_r && !wr_data_r[`BPC_OC_RELEASE]) begin
				release_armed_r <= 1'b1;
			end
		end
	end

	// parity fault is sticky until reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			parity_r <= 1'b0;
			alert_output_n <= 1'b1;
		end else begin
			parity_r <= parity_r | parity_in;
			alert_output_n <= !(parity_r | parity_in);
		end
	end

	// stand-alone protection; host mode follows the control bits
	assign dsg_allow = !(fault_r[`BPC_ST_SHORT] || fault_r[`BPC_ST_OVERLOAD] || fault_r[`BPC_ST_LOW] || parity_r);
	assign chg_allow = !(fault_r[`BPC_ST_HIGH] || fault_r[`BPC_ST_TEMP] || parity_r);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			discharge_fet <= 1'b0;
			charge_fet <= 1'b0;
			open_drain_output_out <= 1'b0;
			open_drain_output_oe_n <= 1'b1;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			if (host_r) begin
				discharge_fet <= dsg_ctl_r && !shutdown_request_r;
				charge_fet <= chg_ctl_r;
				open_drain_output_oe_n <= !odrain_r;
			end else begin
				discharge_fet <= dsg_allow;
				charge_fet <= chg_allow;
				open_drain_output_oe_n <= !(odrain_r && !parity_r);
			end
			open_drain_output_out <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= !drive_low_r;
		end
	end

	// mode and amplifier outputs, shutdown entry
	always_ff @(posedge clk) begin
		if (!nrst) begin
			host_mode <= 1'b0;
			cell_amp_scale <= 1'b0;
			current_amp_gain <= 1'b0;
			shutdown_enter <= 1'b0;
		end else begin
			host_mode <= host_r;
			cell_amp_scale <= vscale_r;
			current_amp_gain <= current_amp_gain_r;
			if (host_r) begin
				shutdown_enter <= shutdown_request_r && pack_zero;
			end else begin
				shutdown_enter <= fault_r[`BPC_ST_LOW] && pack_zero;
			end
		end
	end

	assign function_ctrl = misc_r[0];
	assign cell_balance = misc_r[1];
	assign cell_select = misc_r[2];

	// per-cell undervoltage sampling strobe
	assign sample_limit = rate_sel_r ? UV_FAST_CYCLES[23:0] : UV_SLOW_CYCLES[23:0];
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sample_cnt_r <= 24'h00_0001;
			uv_sample_strobe <= 1'b0;
		end else if (sample_cnt_r >= sample_limit) begin
			sample_cnt_r <= 24'h00_0001;
			uv_sample_strobe <= 1'b1;
		end else begin
			sample_cnt_r <= sample_cnt_r + 24'h00_0001;
			uv_sample_strobe <= 1'b0;
		end
	end

endmodule : bpc_regs

// file: test/bpc_regs_asserts.sv
// port-level checks of the protector register bank
`timescale 1ns/1ns
module bpc_regs_asserts #(
	parameter int unsigned UV_SLOW_CYCLES = 20,
	parameter int unsigned UV_FAST_CYCLES = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_oe_n,
	input wire logic parity_error_detect,
	input wire logic pack_zero_detect,
	input wire logic discharge_fet,
	input wire logic charge_fet,
	input wire logic open_drain_output_oe_n,
	input wire logic alert_output_n,
	input wire logic uv_sample_strobe,
	input wire logic shutdown_enter,
	input wire logic host_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	int unsigned gap_r;
	logic seen_r;
	always_ff @(posedge clk) begin
		if (!nrst || uv_sample_strobe) gap_r <= 0;
		else gap_r <= gap_r + 1;
	end
	always_ff @(posedge clk) begin
		if (!nrst) seen_r <= 1'b0;
		else if (uv_sample_strobe) seen_r <= 1'b1;
	end
	property p_ack_set;
		$fell(sda_oe_n) |-> !scl_in;
	endproperty
	a_ack_set: assert property (p_ack_set) else $error("data drive starts with scl high");
	property p_ack_rel;
		$rose(sda_oe_n) |-> !scl_in;
	endproperty
	a_ack_rel: assert property (p_ack_rel) else $error("data release with scl high");
	property p_alert_set;
		$rose(parity_error_detect) |-> ##[1:6] !alert_output_n;
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("parity fault not flagged");
	property p_alert_hold;
		!alert_output_n |=> !alert_output_n;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("parity fault lost");
	property p_host_par;
		host_mode && $fell(alert_output_n) |-> $stable(discharge_fet) && $stable(charge_fet);
	endproperty
	a_host_par: assert property (p_host_par) else $error("host fets moved on parity");
	property p_sa_fets;
		(!host_mode && !alert_output_n) [*4] |-> !discharge_fet && !charge_fet;
	endproperty
	a_sa_fets: assert property (p_sa_fets) else $error("fets on after parity");
	property p_sa_od;
		(!host_mode && !alert_output_n) [*4] |-> open_drain_output_oe_n;
	endproperty
	a_sa_od: assert property (p_sa_od) else $error("open drain driven after parity");
	property p_shutdown_request;
		!pack_zero_detect [*6] |-> !shutdown_enter;
	endproperty
	a_shutdown_request: assert property (p_shutdown_request) else $error("shutdown above 0 V");
	property p_pulse;
		uv_sample_strobe |=> !uv_sample_strobe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe too long");
	property p_gap;
		uv_sample_strobe && seen_r |-> gap_r >= UV_FAST_CYCLES - 1 && gap_r <= UV_SLOW_CYCLES - 1;
	endproperty
	a_gap: assert property (p_gap) else $error("strobe spacing wrong");
	c_ack: cover property ($fell(sda_oe_n));
	c_shutdown_request: cover property ($rose(shutdown_enter));
	c_fast: cover property (uv_sample_strobe && gap_r == UV_FAST_CYCLES - 1);
endmodule : bpc_regs_asserts

// file: test/bpc_host.sv
// host master model of the serial register bus
`timescale 1ns/1ns
module bpc_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	logic nak;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		nak = 1'b0;
	end
	task automatic hp;
		repeat (8) @(posedge clk);
	endtask : hp
	task automatic bx(input logic b, output logic r);
		sda_low <= !b;
		hp;
		scl <= 1'b1;
		hp;
		r = sda;
		scl <= 1'b0;
		hp;
	endtask : bx
	task automatic st;
		sda_low <= 1'b1;
		hp;
		scl <= 1'b0;
		hp;
	endtask : st
	task automatic sp;
		sda_low <= 1'b1;
		hp;
		scl <= 1'b1;
		hp;
		sda_low <= 1'b0;
		hp;
	endtask : sp
	task automatic wb(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bx(d[i], r);
		bx(1'b1, r);
		nak = nak | r;
	endtask : wb
	task automatic rb(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bx(1'b1, r);
			d[i] = r;
		end
		bx(1'b1, r);
	endtask : rb
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
		nak = 1'b0;
		st;
		wb({a, 1'b0});
		wb(p);
		wb(d);
		sp;
	endtask : wr
	task automatic rr(input logic [6:0] a, output logic [7:0] d);
		st;
		wb({a, 1'b1});
		rb(d);
		sp;
	endtask : rr
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
		nak = 1'b0;
		st;
		wb({a, 1'b0});
		wb(p);
		sp;
		rr(a, d);
	endtask : rd
endmodule : bpc_host

// file: test/testbench.sv
// self-checking bench of the protector register bank
`timescale 1ns/1ns
`include "bpc_consts.svh"
module testbench;
	logic clk, nrst, scl_in, sda_in, sda_out, sda_oe_n, sda_low, parity_error_detect, pack_zero_detect;
	logic discharge_fet, charge_fet, open_drain_output_out, open_drain_output_oe_n, alert_output_n;
	logic uv_sample_strobe, shutdown_enter, host_mode, cell_amp_scale, current_amp_gain;
	logic [7:0] function_ctrl, cell_balance, cell_select, det, g, o;
	int miscompares = 0, check_count = 0, cyc = 0;
	assign sda_in = (sda_oe_n | sda_out) & !sda_low;
	assign o = {2'h0, discharge_fet, charge_fet, open_drain_output_oe_n, alert_output_n, shutdown_enter, host_mode};
	bpc_regs #(.UV_SLOW_CYCLES(20), .UV_FAST_CYCLES(5)) bpc_regs_inst (
		.short_circuit_detect(det[0]),
		.overload_detect(det[1]),
		.cell_high_detect(det[2]),
		.cell_low_detect(det[3]),
		.over_temp_detect(det[4]),
		.nvm_supply_detect(det[5]),
		.discharge_fet_sense(det[6]),
		.charge_fet_sense(det[7]),
		.*
	);
	bpc_host bpc_host_inst (.clk(clk), .sda(sda_in), .scl(scl_in), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task automatic ck(input logic [7:0] a, input logic [7:0] e);
		check_count++;
		if (a !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, a, e);
		end
	endtask : ck
	task automatic w(input logic [7:0] p, input logic [7:0] d);
		bpc_host_inst.wr(`BPC_BUS_ADDR, p, d);
	endtask : w
	task automatic r(input logic [7:0] p);
		bpc_host_inst.rd(`BPC_BUS_ADDR, p, g);
	endtask : r
	task automatic per(output logic [7:0] n);
		repeat (3) begin
			n = 8'h00;
			do begin
				@(posedge clk);
				n++;
			end while (uv_sample_strobe !== 1'b1 && n < 8'h3c);
		end
	endtask : per
	task automatic t_reset;
		ck(o, 8'h3c);
		ck({6'h0, sda_out, open_drain_output_out}, 8'h00);
		r(8'h01);
		ck(g, 8'h00);
		r(8'h02);
		ck(g, 8'h00);
	endtask : t_reset
	task automatic t_fets;
		logic [7:0] v [4] = '{8'h02, 8'h04, 8'h08, 8'h00};
		w(8'h02, 8'h02);
		foreach (v[i]) begin
			w(8'h01, v[i]);
			ck(o, {2'h0, v[i][1], v[i][2], !v[i][3], 3'b101});
			r(8'h01);
			ck(g, v[i]);
		end
	endtask : t_fets
	task automatic t_status;
		for (int i = 0; i < 8; i++) begin
			det <= 8'h01 << i;
			r(8'h00);
			ck(g, (i < 5) ? (8'h02 << i) - 8'h01 : 8'h1f | 8'h01 << i);
		end
		det <= 8'h00;
		r(8'h00);
		ck(g, 8'h1f);
		w(8'h01, 8'h01);
		w(8'h01, 8'h00);
		r(8'h00);
		r(8'h00);
		ck(g, 8'h00);
	endtask : t_status
	task automatic t_state;
		logic [7:0] v [3] = '{8'h42, 8'h82, 8'h02};
		foreach (v[i]) begin
			w(8'h02, v[i]);
			ck({6'h0, v[i][7:6]}, {6'h0, current_amp_gain, cell_amp_scale});
			r(8'h02);
			ck(g, v[i]);
		end
		w(8'h00, 8'hff);
		r(8'h00);
		ck(g, 8'h00);
		w(8'h01, 8'h40);
		r(8'h01);
		ck(g, 8'h00);
	endtask : t_state
	task automatic t_store;
		for (int p = 3; p < 13; p++) w(p[7:0], 8'ha0 + p[7:0]);
		ck({7'h0, bpc_host_inst.nak}, 8'h00);
		ck(function_ctrl, 8'ha3);
		ck(cell_balance, 8'ha4);
		ck(cell_select, 8'ha5);
		for (int p = 3; p < 13; p++) begin
			r(p[7:0]);
			ck(g, (p < 12) ? 8'ha0 + p[7:0] : 8'h00);
		end
		r(8'h07);
		bpc_host_inst.rr(`BPC_BUS_ADDR, g);
		ck(g, 8'ha7);
		bpc_host_inst.wr(7'h11, 8'h03, 8'h55);
		ck({7'h0, bpc_host_inst.nak}, 8'h01);
		ck(function_ctrl, 8'ha3);
	endtask : t_store
	task automatic t_shutdown_request;
		w(8'h01, 8'h02);
		w(8'h02, 8'h03);
		repeat (10) @(posedge clk);
		ck(o, 8'h0d);
		pack_zero_detect <= 1'b1;
		repeat (10) @(posedge clk);
		ck(o, 8'h0f);
		pack_zero_detect <= 1'b0;
		w(8'h02, 8'h02);
		ck(o, 8'h2d);
	endtask : t_shutdown_request
	task automatic t_rate;
		logic [7:0] n;
		w(8'h01, 8'h80);
		per(n);
		ck(n, 8'h05);
		w(8'h01, 8'h00);
		per(n);
		ck(n, 8'h14);
	endtask : t_rate
	task automatic t_parity;
		w(8'h01, 8'h0e);
		parity_error_detect <= 1'b1;
		@(posedge clk);
		parity_error_detect <= 1'b0;
		repeat (10) @(posedge clk);
		ck(o, 8'h31);
		r(8'h01);
		ck(g, 8'h4e);
		w(8'h02, 8'h00);
		repeat (10) @(posedge clk);
		ck(o, 8'h08);
	endtask : t_parity
	initial begin
		nrst = 1'b0;
		det = 8'h00;
		parity_error_detect = 1'b0;
		pack_zero_detect = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset;
		t_fets;
		t_status;
		t_state;
		t_store;
		t_shutdown_request;
		t_rate;
		t_parity;
		close_out;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			miscompares++;
			close_out;
		end
	end
endmodule : testbench
bind bpc_regs bpc_regs_asserts #(.UV_SLOW_CYCLES(UV_SLOW_CYCLES), .UV_FAST_CYCLES(UV_FAST_CYCLES)) bpc_regs_asserts_inst (.*);
